/* include/fcd_cfg.svh */
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH
// Register byte offsets
`define FCD_A_DIV      8'h00
`define FCD_A_STAT     8'h04
`define FCD_A_PPROT    8'h08
`define FCD_A_DPROT    8'h0c
`define FCD_A_BUF0     8'h10
`define FCD_A_BUF3     8'h1c
`define FCD_A_MARGIN   8'h20
// Status bits
`define FCD_B_DONE     7
`define FCD_B_BADACC   5
`define FCD_B_FPVIOL   4
// Protection bits
`define FCD_B_POPEN    7
`define FCD_B_PHDIS    5
`define FCD_B_PLDIS    2
`define FCD_B_DOPEN    7
// Command codes
`define FCD_C_EVALL    8'h01
`define FCD_C_EVBLK    8'h02
`define FCD_C_RDONCE   8'h04
`define FCD_C_PGMP     8'h06
`define FCD_C_PGMONCE  8'h07
`define FCD_C_ERALL    8'h08
`define FCD_C_ERBLK    8'h09
`define FCD_C_ERPSEC   8'h0a
`define FCD_C_UNSEC    8'h0b
`define FCD_C_KEYVFY   8'h0c
`define FCD_C_UMARGIN  8'h0d
`define FCD_C_FMARGIN  8'h0e
`define FCD_C_EVDSEC   8'h10
`define FCD_C_PGMD     8'h11
`define FCD_C_ERDSEC   8'h12
// Block select in buffer word 0 bits [1:0]
`define FCD_BLK_PFLASH 2'h0
`define FCD_BLK_DFLASH 2'h1
// Reset values
`define FCD_RST_PROT   8'h00
`define FCD_RST_DIV    7'h00
`endif

/* include/fcd_pkg.sv */
package fcd_pkg;
   typedef enum logic [0:0] {
      FCD_IDLE = 1'b0,
      FCD_BUSY = 1'b1
   } fcd_state_t;
   // Request to the array engine, taken from the command buffer at launch
   typedef struct packed {
      logic [7:0]  code;
      logic [1:0]  blk;
      logic [15:0] addr;
      logic [15:0] data0;
      logic [15:0] data1;
   } fcd_op_t;
endpackage

/* tb/fcd_decode_test.sv */
`timescale 1ns/10ps
`include "fcd_cfg.svh"
module fcd_decode_test;
   import fcd_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        special_mode_pin;
   logic        array_done;
   logic        array_pass;
   logic [15:0] array_rdata;
   logic        op_start;
   fcd_op_t     op;
   logic        secured;
   fcd_op_t     seen_op;
   logic [31:0] rd;
   logic        err;
   int          errors;
   int          compares;
   int          starts;
   logic [7:0]  bad [3] = '{8'h00, 8'h05, 8'h13};
   logic [7:0]  code_t [10] = '{`FCD_C_EVBLK, `FCD_C_PGMP, `FCD_C_PGMONCE, `FCD_C_RDONCE, `FCD_C_ERPSEC,
                                `FCD_C_KEYVFY, `FCD_C_UMARGIN, `FCD_C_EVDSEC, `FCD_C_PGMD, `FCD_C_ERDSEC};

   fcd_decode fcd_decode_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .special_mode_pin(special_mode_pin), .array_done(array_done),
      .array_pass(array_pass), .array_rdata(array_rdata), .op_start(op_start), .op(op),
      .secured(secured));

   always #25 pclk = ~pclk;

   // The request pulse lasts one cycle, so it is caught at one edge only
   always @(posedge pclk) begin
      if (op_start === 1'b1) begin
         starts  <= starts + 1;
         seen_op <= op;
      end
   end

   task automatic results();
      $display("Counts: %0d compares, %0d errors", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Bus master: request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         $display("MISMATCH at %0t: bus never ready", $time);
         results();
      end
   endtask

   // Outcome 0 accepted, 1 access error, 2 protection violation
   task automatic run(input logic [7:0] code, input logic [1:0] blk, input logic [15:0] p,
                      input logic pass, input int outcome);
      int          s0;
      logic [15:0] res;
      res = {8'h5a, code};
      apb(1'b1, `FCD_A_BUF0, {16'h0, code, 6'h0, blk});
      apb(1'b1, 8'h14, {16'h0, p});
      apb(1'b1, 8'h18, 32'h1234);
      apb(1'b1, `FCD_A_BUF3, {16'h0, ~p});
      s0 = starts;
      apb(1'b1, `FCD_A_STAT, 32'h80);
      if (outcome == 0) begin
         // Buffer write and relaunch while busy must both be dropped
         apb(1'b1, 8'h18, 32'hbeef);
         apb(1'b1, `FCD_A_STAT, 32'h80);
         apb(1'b0, `FCD_A_STAT, 32'h0);
         chk(rd & 32'h80, 32'h0, "flag while busy");
         chk(starts - s0, 32'h1, "request count");
         chk({22'h0, seen_op.code, seen_op.blk}, {22'h0, code, blk}, "op code");
         chk({seen_op.addr, seen_op.data0}, {p, 16'h1234}, "op params");
         chk({16'h0, seen_op.data1}, {16'h0, ~p}, "op data1");
         @(posedge pclk);
         array_done  <= 1'b1;
         array_pass  <= pass;
         array_rdata <= res;
         @(posedge pclk);
         array_done  <= 1'b0;
         apb(1'b0, `FCD_A_STAT, 32'h0);
         chk(rd & 32'hb2, {24'h0, 1'b1, 5'h0, ~pass, 1'b0}, "done status");
         apb(1'b0, 8'h14, 32'h0);
         chk(rd, {16'h0, res}, "result word");
         apb(1'b0, 8'h18, 32'h0);
         chk(rd, 32'h1234, "busy write kept out");
      end else begin
         apb(1'b0, `FCD_A_STAT, 32'h0);
         chk(rd & 32'hb0, (outcome == 1) ? 32'ha0 : 32'h90, "refusal status");
         chk(starts - s0, 32'h0, "no request");
         apb(1'b1, `FCD_A_STAT, 32'h30);
         apb(1'b0, `FCD_A_STAT, 32'h0);
         chk(rd & 32'hb0, 32'h80, "errors cleared");
      end
      $display("test code %h done", code);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      special_mode_pin = 0; array_done = 0; array_pass = 0; array_rdata = 0;
      errors = 0; compares = 0; starts = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `FCD_A_STAT, 32'h0);
      chk(rd, 32'h80, "status at reset");
      apb(1'b0, `FCD_A_DIV, 32'h0);
      chk(rd, 32'h0, "divider at reset");
      apb(1'b0, `FCD_A_MARGIN, 32'h0);
      chk(rd, 32'h80, "margin at reset");
      chk({31'h0, secured}, 32'h1, "secured at reset");
      apb(1'b0, 8'h24, 32'h0);
      chk({rd[30:0], err}, 32'h1, "unmapped read");
      $display("test reset done");
      run(`FCD_C_EVALL, 2'h0, 16'h0, 1'b1, 0);
      run(`FCD_C_PGMP, 2'h0, 16'h0100, 1'b1, 1);
      run(`FCD_C_ERDSEC, 2'h1, 16'h0040, 1'b1, 1);
      apb(1'b1, `FCD_A_DIV, 32'h13);
      apb(1'b0, `FCD_A_DIV, 32'h0);
      chk(rd, 32'h93, "divider loaded");
      foreach (bad[i]) run(bad[i], 2'h0, 16'h0, 1'b1, 1);
      // Key check fails here so security must stay set
      foreach (code_t[i]) run(code_t[i], 2'h1, (code_t[i] == `FCD_C_PGMONCE) ? 16'h3 : 16'h2,
                              code_t[i] != `FCD_C_KEYVFY, 0);
      chk({31'h0, secured}, 32'h1, "failed key keeps security");
      run(`FCD_C_PGMONCE, 2'h0, 16'h3, 1'b1, 1);
      run(`FCD_C_PGMONCE, 2'h0, 16'h4, 1'b1, 0);
      run(`FCD_C_FMARGIN, 2'h0, 16'h1, 1'b1, 1);
      special_mode_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      run(`FCD_C_FMARGIN, 2'h0, 16'h1, 1'b1, 0);
      apb(1'b0, `FCD_A_MARGIN, 32'h0);
      chk(rd, 32'he6, "margin levels");
      apb(1'b1, `FCD_A_PPROT, 32'h24);
      run(`FCD_C_ERBLK, `FCD_BLK_PFLASH, 16'h0, 1'b1, 2);
      apb(1'b1, `FCD_A_PPROT, 32'ha4);
      run(`FCD_C_ERBLK, `FCD_BLK_DFLASH, 16'h0, 1'b1, 2);
      run(`FCD_C_ERALL, 2'h0, 16'h0, 1'b1, 2);
      run(`FCD_C_ERBLK, `FCD_BLK_PFLASH, 16'h0, 1'b1, 0);
      apb(1'b1, `FCD_A_PPROT, 32'ha0);
      apb(1'b1, `FCD_A_DPROT, 32'h80);
      run(`FCD_C_ERALL, 2'h0, 16'h0, 1'b1, 2);
      run(`FCD_C_ERBLK, `FCD_BLK_DFLASH, 16'h0, 1'b1, 0);
      apb(1'b1, `FCD_A_PPROT, 32'ha4);
      run(`FCD_C_ERALL, 2'h0, 16'h0, 1'b1, 0);
      run(`FCD_C_UNSEC, 2'h0, 16'h0, 1'b1, 0);
      chk({31'h0, secured}, 32'h0, "security released");
      apb(1'b0, `FCD_A_MARGIN, 32'h0);
      chk(rd, 32'h66, "margin after release");
      results();
   end
endmodule

/* verilog/fcd_decode.sv */
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "fcd_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE_01: Code 04 reads back one-time 64-byte field
// RULE_02: Code 06 programs one program-flash phrase
// RULE_03: Code 07 writes one-time field, once only
// RULE_04: Code 08 erases all blocks
// RULE_05: Erase-all needs all four protection bits set
// RULE_06: Program block erase needs three protection bits
// RULE_07: Data block erase needs data open bit
// RULE_08: Code 0A erases program-flash sector
// RULE_09: Code 0B erases, verifies, releases security
// RULE_10: Code 0C releases security on key match
// RULE_11: Code 0D sets user margin level
// RULE_12: Code 0E field margin, special mode only
// RULE_13: Code 01 verifies all blocks erased
// RULE_14: Code 02 verifies selected block erased
// RULE_15: Code 10 verifies data-flash words erased
// RULE_16: Code 11 programs one to four words; the request carries only two data words (data0, data1)
// RULE_17: Code 12 erases data-flash sector
// RULE_18: Write one clears completion flag; set when done
// RULE_19: Divider unwritten refuses program/erase, access error
// RULE_20: Unknown code sets access error, no run
// RULE_21: Blocked full erase keeps array, flags error
//////////////////////////////////////////////////////////////////////////////
module fcd_decode (
   input  wire logic                 pclk,             // Bus clock
   input  wire logic                 presetn,          // Async reset, active low
   input  wire logic                 psel,             // APB select
   input  wire logic                 penable,          // APB enable
   input  wire logic                 pwrite,           // APB direction
   input  wire logic [7:0]           paddr,            // APB byte address
   input  wire logic [31:0]          pwdata,           // APB write data
   output logic      [31:0]          prdata,           // APB read data
   output logic                      pready,           // APB ready
   output logic                      pslverr,          // APB error
   input  wire logic                 special_mode_pin, // Special mode strap pin
   input  wire logic                 array_done,       // Array engine finished
   input  wire logic                 array_pass,       // Array result good
   input  wire logic [15:0]          array_rdata,      // Array result word
   output logic                      op_start,         // One-cycle request pulse
   output fcd_pkg::fcd_op_t          op,               // Request contents
   output logic                      secured           // Device security state
);
   import fcd_pkg::*;

   logic [6:0]       div_q;
   logic             divld_q;
   logic             done_q;
   logic             badacc_q;
   logic             fpviol_q;
   logic [1:0]       mgstat_q;
   logic [7:0]       pprot_q;
   logic [7:0]       dprot_q;
   logic [15:0]      buf_q [0:3];
   logic [1:0]       umargin_q;
   logic [1:0]       fmargin_q;
   logic [7:0]       once_q;
   logic             spec_s1_q;
   logic             spec_q;
   logic             op_start_q;
   fcd_op_t          op_q;
   logic             secured_q;
   fcd_state_t       state_q;
   logic             wr;
   logic             mapped;
   logic             launch;
   logic             err_acc;
   logic             err_viol;
   logic [7:0]       code;
   logic [1:0]       blk;
   logic             pall;
   logic             dopen;

   function automatic logic fcd_valid(input logic [7:0] c);
      case (c)
         `FCD_C_EVALL, `FCD_C_EVBLK, `FCD_C_EVDSEC,               // RULE_13 RULE_14 RULE_15
         `FCD_C_RDONCE, `FCD_C_PGMP, `FCD_C_PGMONCE,              // RULE_01 RULE_02 RULE_03
         `FCD_C_ERALL, `FCD_C_ERBLK, `FCD_C_ERPSEC,               // RULE_04 RULE_08
         `FCD_C_UNSEC, `FCD_C_KEYVFY,                             // RULE_09 RULE_10
         `FCD_C_UMARGIN, `FCD_C_FMARGIN,                          // RULE_11 RULE_12
         `FCD_C_PGMD, `FCD_C_ERDSEC: fcd_valid = 1'b1;            // RULE_16 RULE_17
         default:                    fcd_valid = 1'b0;
      endcase
   endfunction

   // Commands that program or erase and so depend on the timebase
   function automatic logic fcd_pe(input logic [7:0] c);
      case (c)
         `FCD_C_PGMP, `FCD_C_PGMONCE, `FCD_C_ERALL, `FCD_C_ERBLK,
         `FCD_C_ERPSEC, `FCD_C_UNSEC, `FCD_C_PGMD, `FCD_C_ERDSEC: fcd_pe = 1'b1;
         default:                                                 fcd_pe = 1'b0;
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, error on unmapped offsets
   assign pready  = 1'b1;
   assign wr      = psel && penable && pwrite;
   assign mapped  = (paddr <= `FCD_A_MARGIN) && (paddr[1:0] == 2'h0);
   assign pslverr = psel && penable && !mapped;

   always_comb begin
      prdata = 32'h0;
      case (paddr)
         `FCD_A_DIV:    prdata[7:0] = {divld_q, div_q};
         `FCD_A_STAT:   prdata[7:0] = {done_q, 1'b0, badacc_q, fpviol_q, 2'h0, mgstat_q};
         `FCD_A_PPROT:  prdata[7:0] = pprot_q;
         `FCD_A_DPROT:  prdata[7:0] = dprot_q;
         `FCD_A_MARGIN: prdata[7:0] = {secured_q, spec_q, once_q != 8'h00, 1'b0, fmargin_q, umargin_q};
         default: begin
            if (paddr >= `FCD_A_BUF0 && paddr <= `FCD_A_BUF3) begin
               prdata[15:0] = buf_q[paddr[3:2]];
            end
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Launch decode
   assign code   = buf_q[0][15:8];
   assign blk    = buf_q[0][1:0];
   assign pall   = pprot_q[`FCD_B_PLDIS] && pprot_q[`FCD_B_PHDIS] && pprot_q[`FCD_B_POPEN];
   assign dopen  = dprot_q[`FCD_B_DOPEN];
   // Launch is ignored while a command runs or an old error is still set
   assign launch = wr && paddr == `FCD_A_STAT && pwdata[`FCD_B_DONE] && done_q && !badacc_q && !fpviol_q; // RULE_18

   always_comb begin
      err_acc = !fcd_valid(code);                                           // RULE_20
      if (fcd_pe(code) && !divld_q) begin
         err_acc = 1'b1;                                                    // RULE_19
      end
      if (code == `FCD_C_FMARGIN && !spec_q) begin
         err_acc = 1'b1;                                                    // RULE_12
      end
      if (code == `FCD_C_PGMONCE && once_q[buf_q[1][2:0]]) begin
         err_acc = 1'b1;                                                    // RULE_03
      end
      err_viol = 1'b0;
      if (!err_acc && code == `FCD_C_ERALL && !(pall && dopen)) begin
         err_viol = 1'b1;                                                   // RULE_05 RULE_21
      end
      if (!err_acc && code == `FCD_C_ERBLK) begin
         err_viol = (blk == `FCD_BLK_PFLASH) ? !pall : !dopen;              // RULE_06 RULE_07 RULE_21
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Special mode pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spec_s1_q <= 1'b0;
         spec_q    <= 1'b0;
      end else begin
         spec_s1_q <= special_mode_pin;
         spec_q    <= spec_s1_q;
      end
   end

   // Timebase divider; the loaded flag is sticky until reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q   <= `FCD_RST_DIV;
         divld_q <= 1'b0;
      end else if (wr && paddr == `FCD_A_DIV && done_q) begin
         div_q   <= pwdata[6:0];
         divld_q <= 1'b1;
      end
   end

   // Protection registers; frozen while a command runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pprot_q <= `FCD_RST_PROT;
         dprot_q <= `FCD_RST_PROT;
      end else if (wr && done_q) begin
         if (paddr == `FCD_A_PPROT) begin
            pprot_q <= pwdata[7:0];
         end
         if (paddr == `FCD_A_DPROT) begin
            dprot_q <= pwdata[7:0];
         end
      end
   end

   // Command buffer: software loads it while idle, results land in word 1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            buf_q[i] <= 16'h0;
         end
      end else if (state_q == FCD_BUSY && array_done) begin
         buf_q[1] <= array_rdata;                                           // RULE_18 RULE_01
      end else if (wr && done_q && paddr >= `FCD_A_BUF0 && paddr <= `FCD_A_BUF3) begin
         buf_q[paddr[3:2]] <= pwdata[15:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= FCD_IDLE;
         done_q     <= 1'b1;
         op_start_q <= 1'b0;
         op_q       <= '0;
      end else begin
         op_start_q <= 1'b0;
         case (state_q)
            FCD_IDLE: begin
               if (launch && !err_acc && !err_viol) begin
                  state_q    <= FCD_BUSY;
                  done_q     <= 1'b0;                                       // RULE_18
                  op_start_q <= 1'b1;
                  op_q       <= '{code: code, blk: blk, addr: buf_q[1], data0: buf_q[2], data1: buf_q[3]};
               end
            end
            FCD_BUSY: begin
               if (array_done) begin
                  state_q <= FCD_IDLE;
                  done_q  <= 1'b1;                                          // RULE_18
               end
            end
            default: state_q <= FCD_IDLE;
         endcase
      end
   end

   // Error flags: write one clears, a new error in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         badacc_q <= 1'b0;
         fpviol_q <= 1'b0;
      end else begin
         if (launch && err_acc) begin
            badacc_q <= 1'b1;                                               // RULE_19 RULE_20
         end else if (wr && paddr == `FCD_A_STAT && pwdata[`FCD_B_BADACC]) begin
            badacc_q <= 1'b0;
         end
         if (launch && err_viol) begin
            fpviol_q <= 1'b1;                                               // RULE_21
         end else if (wr && paddr == `FCD_A_STAT && pwdata[`FCD_B_FPVIOL]) begin
            fpviol_q <= 1'b0;
         end
      end
   end

   // Completion side effects
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mgstat_q  <= 2'h0;
         umargin_q <= 2'h0;
         fmargin_q <= 2'h0;
         once_q    <= 8'h00;
         secured_q <= 1'b1;
      end else if (state_q == FCD_BUSY && array_done) begin
         mgstat_q <= {!array_pass, 1'b0};
         if (op_q.code == `FCD_C_PGMONCE) begin
            once_q[op_q.addr[2:0]] <= 1'b1;                                 // RULE_03
         end
         if ((op_q.code == `FCD_C_UNSEC || op_q.code == `FCD_C_KEYVFY) && array_pass) begin
            secured_q <= 1'b0;                                              // RULE_09 RULE_10
         end
         if (op_q.code == `FCD_C_UMARGIN && array_pass) begin
            umargin_q <= op_q.addr[1:0];                                    // RULE_11
         end
         if (op_q.code == `FCD_C_FMARGIN && array_pass) begin
            fmargin_q <= op_q.addr[1:0];                                    // RULE_12
         end
      end
   end

   assign op_start = op_start_q;
   assign op       = op_q;
   assign secured  = secured_q;

   //////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_good_launch;
      launch && !err_acc && !err_viol && state_q == FCD_IDLE;
   endsequence

   sequence s_start_pulse;
      op_start_q && !done_q ##1 !op_start_q;
   endsequence

   property p_launch_starts;
      @(posedge pclk) disable iff (!presetn) s_good_launch |=> s_start_pulse;
   endproperty
   a_launch_starts: assert property (p_launch_starts) else $error("Launch did not start"); // RULE_18

   property p_code_carried;
      @(posedge pclk) disable iff (!presetn) s_good_launch |=> op_q.code == $past(code);
   endproperty
   a_code_carried: assert property (p_code_carried) else $error("Wrong code issued"); // RULE_02

   property p_busy_holds;
      @(posedge pclk) disable iff (!presetn) (!done_q && !array_done) |=> !done_q;
   endproperty
   a_busy_holds: assert property (p_busy_holds) else $error("Flag rose early"); // RULE_18

   property p_done_sets;
      @(posedge pclk) disable iff (!presetn) (state_q == FCD_BUSY && array_done) |=> done_q && state_q == FCD_IDLE;
   endproperty
   a_done_sets: assert property (p_done_sets) else $error("Flag not set at end"); // RULE_18

   property p_bad_code;
      @(posedge pclk) disable iff (!presetn) (launch && !fcd_valid(code)) |=> badacc_q && done_q && !op_start_q;
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("Bad code not refused"); // RULE_20

   property p_no_div;
      @(posedge pclk) disable iff (!presetn) (launch && fcd_pe(code) && !divld_q) |=> badacc_q && !op_start_q;
   endproperty
   a_no_div: assert property (p_no_div) else $error("Unloaded divider ran"); // RULE_19

   property p_erall_prot;
      @(posedge pclk) disable iff (!presetn)
         (launch && !err_acc && code == `FCD_C_ERALL && !(pall && dopen)) |=> fpviol_q && !op_start_q [*2];
   endproperty
   a_erall_prot: assert property (p_erall_prot) else $error("Erase all ran unprotected"); // RULE_05

   property p_erblk_prot;
      @(posedge pclk) disable iff (!presetn)
         (launch && !err_acc && code == `FCD_C_ERBLK && (blk == `FCD_BLK_PFLASH ? !pall : !dopen))
         |=> fpviol_q && done_q;
   endproperty
   a_erblk_prot: assert property (p_erblk_prot) else $error("Block erase ran unprotected"); // RULE_06

   property p_field_special;
      @(posedge pclk) disable iff (!presetn) (launch && code == `FCD_C_FMARGIN && !spec_q) |=> badacc_q;
   endproperty
   a_field_special: assert property (p_field_special) else $error("Field margin outside special"); // RULE_12

   property p_once_only;
      @(posedge pclk) disable iff (!presetn)
         (launch && code == `FCD_C_PGMONCE && once_q[buf_q[1][2:0]]) |=> badacc_q && !op_start_q;
   endproperty
   a_once_only: assert property (p_once_only) else $error("One-time field rewritten"); // RULE_03
endmodule
